// *** hdl/sent_frame_transmitter.sv ***
// Purpose: SENT frame transmitter on an open-drain single-wire output
// Assumes: Sample inputs are on the clk domain; line input is asynchronous
// Notes: Addressed modes reuse the trigger path without slot counting
`timescale 1ns/1ps
module sent_frame_transmitter (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Open-drain line
   input wire logic lineIn,
   output logic lineOut,
   output logic lineOe,
   // Configuration
   input wire sent_pkg::msg_mode_t msgMode,
   input wire logic [4:0] tickCode,
   input wire logic [1:0] dataCfg,
   input wire logic slowSerDis,
   input wire logic crcHasStatus,
   // Sample sources
   input wire logic [11:0] magOut,
   input wire logic [7:0] diagFlags,
   input wire logic [11:0] tempOut,
   input wire logic [1:0] devStatus,
   input wire logic [1:0] serialBits,
   // Status
   output logic frameActive,
   output logic sampleFresh,
   output logic [11:0] frameCount
);
   import sent_pkg::*;

   localparam int UPD_BOUND = 313;
   localparam int TICK_BOUND = 600;

   // Line synchroniser; only lineSync_r and later are read by logic
   logic lineMeta_r, lineSync_r, lineDly_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineMeta_r <= 1'b1;
         lineSync_r <= 1'b1;
         lineDly_r <= 1'b1;
      end else begin
         lineMeta_r <= lineIn;
         lineSync_r <= lineMeta_r;
         lineDly_r <= lineSync_r;
      end
   end

   // Tick source
   logic tick, restart;
   logic [9:0] tickCyc;
   logic addrMode, contMode;

   assign addrMode = (msgMode == MODE_ADDRESSED_SHARED_BUS) ||
                     (msgMode == MODE_ALTERNATE_ADDRESSED);
   assign contMode = (msgMode == MODE_INT_SYNC);

   sent_tick_gen u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tickCode(tickCode),
      .addrTable(addrMode),
      .restart(restart),
      .tick(tick),
      .tickCyc(tickCyc)
   );

   // Transmit state
   tx_state_t st_r, st_nxt;
   logic [5:0] segTick_r, segTick_nxt;
   logic [2:0] nibIdx_r, nibIdx_nxt;
   logic [2:0] lastIdx_r, lastIdx_nxt;
   logic [3:0] nib_r [8];
   logic [3:0] nib_nxt [8];
   logic lineOe_r, lineOe_nxt;
   logic load;

   // Sample and trigger state
   logic [8:0] updCnt_r, updCnt_nxt;
   logic [11:0] sinceFall_r, sinceFall_nxt;
   logic lowSeen_r, lowSeen_nxt;
   logic pend_r, pend_nxt;
   logic fresh_r, fresh_nxt;
   logic [11:0] magL_r, magL_nxt;
   logic [7:0] diagL_r, diagL_nxt;
   logic [11:0] tempL_r, tempL_nxt;
   logic [11:0] count_r, count_nxt;

   logic updTick, armed, trigFall, trigRise, trigValid, latchEv;
   logic [5:0] tickInc;
   logic [15:0] syncCyc;
   logic [3:0] frameNib [8];
   logic [3:0] crc;
   logic [2:0] lastIdx;

   assign updTick = (updCnt_r == 9'(UPDATE_CYC - 1));
   assign armed = (st_r == ST_PAUSE) && (segTick_r >= LOW_TICKS) && !lineOe_r;
   assign trigFall = armed && lineDly_r && !lineSync_r;
   assign trigRise = armed && !lineDly_r && lineSync_r && lowSeen_r;
   // Short low pulses are glitches, not requests
   assign trigValid = (sinceFall_r >= 12'(TRIG_MIN_CYC));
   assign latchEv = contMode ? updTick : (updTick && pend_r);
   assign tickInc = (segTick_r == 6'h3F) ? segTick_r : segTick_r + 6'h01;
   // Widen before the product so 56 slow ticks do not wrap
   assign syncCyc = 16'(SYNC_TICKS) * 16'(tickCyc);

   // Frame contents built from the latched sample, the live status inputs and the frame count
   always_comb begin
      lastIdx = (dataCfg == 2'h0) ? LAST_IDX_SHORT : LAST_IDX_LONG;
      for (int i = 0; i < 8; i++) begin
         frameNib[i] = 4'h0;
      end
      frameNib[0] = {slowSerDis ? 2'h0 : serialBits, devStatus};
      frameNib[1] = magL_r[11:8];
      frameNib[2] = magL_r[7:4];
      frameNib[3] = magL_r[3:0];
      unique case (dataCfg)
         2'h1: begin
            frameNib[4] = diagL_r[7:4];
            frameNib[5] = diagL_r[3:0];
            frameNib[6] = count_r[3:0];
         end
         2'h2: begin
            frameNib[4] = count_r[11:8];
            frameNib[5] = count_r[7:4];
            frameNib[6] = count_r[3:0];
         end
         2'h3: begin
            frameNib[4] = tempL_r[11:8];
            frameNib[5] = tempL_r[7:4];
            frameNib[6] = tempL_r[3:0];
         end
         2'h0: begin
         end
      endcase
      crc = CRC_SEED;
      if (crcHasStatus) begin
         crc = crc_step(crc, frameNib[0]);
      end
      for (int i = 1; i < 7; i++) begin
         if (3'(i) < lastIdx) begin
            crc = crc_step(crc, frameNib[i]);
         end
      end
      // Trailing zero nibble closes the division
      crc = crc_step(crc, 4'h0);
      frameNib[lastIdx] = crc;
   end

   // Transmit sequencing
   always_comb begin
      st_nxt = st_r;
      segTick_nxt = segTick_r;
      nibIdx_nxt = nibIdx_r;
      lastIdx_nxt = lastIdx_r;
      nib_nxt = nib_r;
      load = 1'b0;
      restart = 1'b0;
      if (tick) begin
         segTick_nxt = tickInc;
      end
      unique case (st_r)
         ST_PAUSE: begin
            if (contMode) begin
               // Stretch the pause until the next update delivered a sample
               if (tick && tickInc > LOW_TICKS && fresh_r) begin
                  st_nxt = ST_SYNC;
                  load = 1'b1;
               end
            end else if (trigRise && trigValid) begin
               st_nxt = ST_GAP;
               segTick_nxt = 6'h00;
               restart = 1'b1;
            end
         end
         ST_GAP: begin
            if (tick && tickInc >= GAP_MIN_TICKS &&
                17'(sinceFall_r) + 17'(syncCyc) + 17'h00001 >=
                17'(TRIG_SYNC_CYC)) begin
               st_nxt = ST_SYNC;
               load = 1'b1;
            end
         end
         ST_SYNC: begin
            if (tick && tickInc == SYNC_TICKS) begin
               st_nxt = ST_NIB;
               segTick_nxt = 6'h00;
               nibIdx_nxt = 3'h0;
            end
         end
         ST_NIB: begin
            if (tick && tickInc == NIB_BASE_TICKS + 6'(nib_r[nibIdx_r])) begin
               segTick_nxt = 6'h00;
               if (nibIdx_r == lastIdx_r) begin
                  st_nxt = ST_PAUSE;
               end else begin
                  nibIdx_nxt = nibIdx_r + 3'h1;
               end
            end
         end
      endcase
      if (load) begin
         segTick_nxt = 6'h00;
         nib_nxt = frameNib;
         lastIdx_nxt = lastIdx;
      end
      // Sync and nibble pulses drive low for a fixed span, then release; the pause pulse drops out after one cycle until its next tick
      lineOe_nxt = (st_nxt != ST_GAP) && (segTick_nxt < LOW_TICKS) &&
                   !(st_nxt == ST_PAUSE && segTick_nxt == 6'h00 &&
                     st_r == ST_PAUSE);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= ST_PAUSE;
         segTick_r <= LOW_TICKS;
         nibIdx_r <= 3'h0;
         lastIdx_r <= LAST_IDX_SHORT;
         for (int i = 0; i < 8; i++) begin
            nib_r[i] <= 4'h0;
         end
         lineOe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         segTick_r <= segTick_nxt;
         nibIdx_r <= nibIdx_nxt;
         lastIdx_r <= lastIdx_nxt;
         nib_r <= nib_nxt;
         lineOe_r <= lineOe_nxt;
      end
   end

   // Sampling, trigger timing and frame counting
   always_comb begin
      updCnt_nxt = updTick ? 9'h000 : updCnt_r + 9'h001;
      sinceFall_nxt = (sinceFall_r == 12'hFFF) ? sinceFall_r :
                      sinceFall_r + 12'h001;
      lowSeen_nxt = lowSeen_r;
      pend_nxt = pend_r;
      fresh_nxt = fresh_r;
      magL_nxt = magL_r;
      diagL_nxt = diagL_r;
      tempL_nxt = tempL_r;
      count_nxt = count_r;
      if (trigFall) begin
         sinceFall_nxt = 12'h000;
         lowSeen_nxt = 1'b1;
         pend_nxt = 1'b1;
      end else if (trigRise || !armed) begin
         lowSeen_nxt = 1'b0;
      end
      if (load) begin
         fresh_nxt = 1'b0;
         if (dataCfg == 2'h1 && count_r == COUNT_WRAP_SHORT) begin
            count_nxt = 12'h000;
         end else begin
            count_nxt = count_r + 12'h001;
         end
      end
      // A new sample in the frame start cycle still counts as fresh
      if (latchEv) begin
         magL_nxt = magOut;
         diagL_nxt = diagFlags;
         tempL_nxt = tempOut;
         fresh_nxt = 1'b1;
         pend_nxt = trigFall;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         updCnt_r <= 9'h000;
         sinceFall_r <= 12'hFFF;
         lowSeen_r <= 1'b0;
         pend_r <= 1'b0;
         fresh_r <= 1'b0;
         magL_r <= 12'h000;
         diagL_r <= 8'h00;
         tempL_r <= 12'h000;
         count_r <= 12'h000;
      end else begin
         updCnt_r <= updCnt_nxt;
         sinceFall_r <= sinceFall_nxt;
         lowSeen_r <= lowSeen_nxt;
         pend_r <= pend_nxt;
         fresh_r <= fresh_nxt;
         magL_r <= magL_nxt;
         diagL_r <= diagL_nxt;
         tempL_r <= tempL_nxt;
         count_r <= count_nxt;
      end
   end

   // Open drain: only ever pulls low
   assign lineOut = 1'b0;
   assign lineOe = lineOe_r;
   assign frameActive = (st_r == ST_SYNC) || (st_r == ST_NIB);
   assign sampleFresh = fresh_r;
   assign frameCount = count_r;

   // Cycle counter inside a segment, read by the checks only
   logic [15:0] segCyc_r;

   always_ff @(posedge clk) begin
      if (!rst_n || load || segTick_nxt == 6'h00 && segTick_r != 6'h00) begin
         segCyc_r <= 16'h0000;
      end else begin
         segCyc_r <= segCyc_r + 16'h0001;
      end
   end

   sequence syncEndSeq;
      st_r == ST_SYNC && st_nxt == ST_NIB;
   endsequence

   sequence nibEndSeq;
      st_r == ST_NIB && segTick_nxt == 6'h00 && tick;
   endsequence

   sequence trigStartSeq;
      trigRise && trigValid && st_r == ST_PAUSE && !contMode;
   endsequence

   chk_sync_len: assert property (@(posedge clk) disable iff (!rst_n)
      syncEndSeq |-> segCyc_r + 16'h0001 == syncCyc)
      else $error("sync pulse length wrong");

   chk_nibble_len: assert property (@(posedge clk) disable iff (!rst_n)
      nibEndSeq |-> segCyc_r + 16'h0001 ==
      16'((16'(NIB_BASE_TICKS) + 16'(nib_r[nibIdx_r])) * tickCyc))
      else $error("nibble length wrong");

   chk_nibble_count: assert property (@(posedge clk) disable iff (!rst_n)
      load |=> lastIdx_r == (($past(dataCfg) == 2'h0) ? LAST_IDX_SHORT :
                             LAST_IDX_LONG))
      else $error("nibble count does not match format");

   chk_status_bits: assert property (@(posedge clk) disable iff (!rst_n)
      load |=> nib_r[0] == {$past(slowSerDis) ? 2'h0 : $past(serialBits),
                            $past(devStatus)})
      else $error("status nibble wrong");

   chk_trig_latch: assert property (@(posedge clk) disable iff (!rst_n)
      (trigFall && !contMode) |-> ##[1:UPD_BOUND] latchEv)
      else $error("trigger sample not latched at next update");

   chk_gap_high: assert property (@(posedge clk) disable iff (!rst_n)
      trigStartSeq |=> (!lineOe_r && st_r == ST_GAP) [*3])
      else $error("line not held high after trigger release");

   chk_gap_min: assert property (
      @(posedge clk) disable iff (!rst_n)
      (st_r == ST_GAP && st_nxt == ST_SYNC) |->
      segCyc_r + 16'h0001 >= 16'(GAP_MIN_TICKS) * 16'(tickCyc))
      else $error("gap before sync too short");

   chk_sync_time: assert property (
      @(posedge clk) disable iff (!rst_n)
      syncEndSeq |-> contMode ||
      13'(sinceFall_r) + 13'h0001 >= 13'(TRIG_SYNC_CYC))
      else $error("sync ended too soon after trigger");

   chk_trig_only: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == ST_PAUSE && st_nxt == ST_GAP) |-> $past(lowSeen_r) &&
      sinceFall_r >= 12'(TRIG_MIN_CYC))
      else $error("frame started without a valid trigger");

   chk_cont_fresh: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == ST_PAUSE && st_nxt == ST_SYNC) |-> fresh_r && contMode)
      else $error("continuous frame started without fresh sample");

   chk_cont_run: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r == ST_PAUSE && contMode && fresh_r && segTick_r > LOW_TICKS)
      |-> ##[0:TICK_BOUND] (st_r == ST_SYNC || !contMode))
      else $error("continuous mode did not start the next frame");
endmodule : sent_frame_transmitter

// *** hdl/sent_tick_gen.sv ***
// Purpose: Tick period generator for the SENT transmitter
// Assumes: Tick code stable while a frame runs
// Notes: Restart realigns the tick grid to a trigger release
`timescale 1ns/1ps
module sent_tick_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic [4:0] tickCode,
   input wire logic addrTable,
   input wire logic restart,
   // Tick
   output logic tick,
   output logic [9:0] tickCyc
);
   import sent_pkg::*;

   logic [9:0] cnt_r, cnt_nxt;
   logic [9:0] tickCyc_r, tickCyc_nxt;

   always_comb begin
      // Addressed modes use the finer table over all 32 codes
      if (addrTable) begin
         tickCyc_nxt = tick_cycles(TICK_ADDR_NS10[tickCode]);
      end else begin
         tickCyc_nxt = tick_cycles(TICK_STD_NS10[tickCode[3:0]]);
      end
      if (restart || cnt_r >= tickCyc_r - 10'h001) begin
         cnt_nxt = 10'h000;
      end else begin
         cnt_nxt = cnt_r + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 10'h000;
         tickCyc_r <= TICK_CYC_RST;
      end else begin
         cnt_r <= cnt_nxt;
         tickCyc_r <= tickCyc_nxt;
      end
   end

   // Tick ignores restart on purpose to keep the path loop free
   assign tick = (cnt_r == tickCyc_r - 10'h001);
   assign tickCyc = tickCyc_r;
endmodule : sent_tick_gen

// *** pkg/sent_pkg.sv ***
// Purpose: Shared constants, types and helpers for the SENT frame transmitter
// Assumes: 40 MHz system clock, 128 kHz internal update rate
// Notes: Tick periods are held in 10 ns units and rounded to nearest cycle
//
// Contract
// - Every frame opens with one sync and calibration pulse of 56 ticks.
// - Next comes one status nibble: bits 1:0 device status, 3:2 serial bits.
// - Then 3 to 6 data nibbles follow, each 12 to 27 ticks long.
// - A CRC nibble of 12 to 27 ticks follows the data nibbles.
// - A pause pulse closes the frame and pads it to the update timing.
// - Four transmission modes are chosen by the output message mode.
// - Mode 1 sends frames back to back, paced by the internal update.
// - In mode 1 the pause is stretched until a fresh sample exists.
// - Mode 2 sends only on request and holds the pause state until then.
// - After a trigger falling edge the sample latches at the next update.
// - The frame starts on the release, with at least 7 high ticks first.
// - The high gap grows so 70.4 us pass from trigger fall to sync end.
// - The tick period follows the tick code, per mode family table.
// - CRC uses x^4+x^3+x^2+1, seed 0101, status optionally included.
// - Data format 0 gives 3 magnetic nibbles; 1 to 3 give 6 nibbles.
package sent_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_NS = 25;
   localparam int UPDATE_HZ = 128_000;
   localparam int UPDATE_CYC = CLK_HZ / UPDATE_HZ;
   localparam int TRIG_LOW_NS = 1800;
   localparam int TRIG_MIN_CYC = (TRIG_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRIG_SYNC_NS = 70400;
   localparam int TRIG_SYNC_CYC = (TRIG_SYNC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] SYNC_TICKS = 6'h38;
   localparam logic [5:0] NIB_BASE_TICKS = 6'h0C;
   localparam logic [5:0] LOW_TICKS = 6'h05;
   localparam logic [5:0] GAP_MIN_TICKS = 6'h07;
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [4:0] CRC_POLY = 5'h1D;
   localparam logic [2:0] LAST_IDX_SHORT = 3'h4;
   localparam logic [2:0] LAST_IDX_LONG = 3'h7;
   localparam logic [11:0] COUNT_WRAP_SHORT = 12'h00F;
   localparam logic [9:0] TICK_CYC_RST = 10'h07A;
   localparam logic [10:0] TICK_STD_NS10 [16] = '{
      11'h131, 11'h131, 11'h131, 11'h131, 11'h5C5, 11'h3C4, 11'h2DC, 11'h262,
      11'h1DC, 11'h162, 11'h0F4, 11'h0AB, 11'h07A, 11'h055, 11'h03D, 11'h03D};
   localparam logic [10:0] TICK_ADDR_NS10 [32] = '{
      11'h00C, 11'h00C, 11'h018, 11'h025, 11'h031, 11'h03D, 11'h049, 11'h055,
      11'h062, 11'h06E, 11'h07A, 11'h086, 11'h092, 11'h09F, 11'h0AB, 11'h0B7,
      11'h0C3, 11'h0D0, 11'h0DC, 11'h0E8, 11'h0F4, 11'h100, 11'h10D, 11'h119,
      11'h125, 11'h131, 11'h13D, 11'h14A, 11'h156, 11'h162, 11'h16E, 11'h17A};

   typedef enum logic [1:0] {
      MODE_ALTERNATE_ADDRESSED = 2'b00,
      MODE_INT_SYNC = 2'b01,
      MODE_TRIGGERED_TRANSMIT = 2'b10,
      MODE_ADDRESSED_SHARED_BUS = 2'b11
   } msg_mode_t;

   typedef enum logic [1:0] {
      ST_PAUSE = 2'b00,
      ST_GAP = 2'b01,
      ST_SYNC = 2'b10,
      ST_NIB = 2'b11
   } tx_state_t;

   function automatic logic [9:0] tick_cycles(input logic [10:0] ns10);
      return 10'((32'(ns10) * 10 + CLK_NS / 2) / CLK_NS);
   endfunction : tick_cycles

   // One nibble of the polynomial division, MSB first
   function automatic logic [3:0] crc_step(input logic [3:0] crc,
                                           input logic [3:0] nib);
      logic [7:0] v;
      v = {crc, 4'h0};
      for (int i = 7; i >= 4; i--) begin
         if (v[i]) begin
            v = v ^ 8'({3'h0, CRC_POLY} << (i - 4));
         end
      end
      return v[3:0] ^ nib;
   endfunction : crc_step
endpackage : sent_pkg

// *** test/sent_frame_transmitter_tb.sv ***
// Purpose: Self-checking bench for the SENT frame transmitter
// Assumes: 40 MHz clock; receiver model pulls the open-drain line
// Notes: Frame count is checked by step, its start value being free
`timescale 1ns/1ps
module sent_frame_transmitter_tb;
   import sent_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic lineOe, lineOut, lineWire, frameActive, sampleFresh, pullLow;
   logic [11:0] frameCount;
   msg_mode_t msgMode = MODE_TRIGGERED_TRANSMIT;
   logic [4:0] tickCode = 5'h0E;
   logic [1:0] dataCfg = 2'h0;
   logic slowSerDis = 1'b0;
   logic crcHasStatus = 1'b0;
   logic [11:0] magOut = 12'h3C1;
   logic [7:0] diagFlags = 8'h96;
   logic [11:0] tempOut = 12'hE71;
   logic [1:0] devStatus = 2'h1;
   logic [1:0] serialBits = 2'h2;
   logic [9:0] tickCyc = 10'h018;
   logic [2:0] nData = 3'h3;
   logic [3:0] expNib [8];
   int nMismatch = 0;
   int totalChecks = 0;
   int prevCnt = -1;
   int mark, span;
   int actCyc = 0;
   int act0 = 0;
   localparam logic [1:0] MODES [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
      2'h3, 2'h0};
   localparam logic [1:0] CFGS [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3,
      2'h0, 2'h0};
   localparam logic [4:0] CODES [7] = '{5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0E,
      5'h05, 5'h05};

   always #12.5 clk = ~clk;
   // Wire is low while either party pulls it
   assign lineWire = !(lineOe | pullLow);

   sent_frame_transmitter i_dut (.clk(clk), .rst_n(rst_n),
      .lineIn(lineWire), .lineOut(lineOut), .lineOe(lineOe),
      .msgMode(msgMode), .tickCode(tickCode), .dataCfg(dataCfg),
      .slowSerDis(slowSerDis), .crcHasStatus(crcHasStatus),
      .magOut(magOut), .diagFlags(diagFlags), .tempOut(tempOut),
      .devStatus(devStatus), .serialBits(serialBits),
      .frameActive(frameActive), .sampleFresh(sampleFresh),
      .frameCount(frameCount));

   sent_receiver_model i_rx (.clk(clk), .rst_n(rst_n), .lineWire(lineWire),
      .pullLow(pullLow), .tickCyc(tickCyc), .nData(nData));

   // Counts cycles spent inside frames
   always @(posedge clk) begin
      if (frameActive === 1'b1) begin
         actCyc <= actCyc + 1;
      end
   end

   task automatic check(input logic ok, input string msg);
      totalChecks++;
      if (ok !== 1'b1) begin
         nMismatch++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic endOfTest;
      $display("Checks %0d, mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endOfTest

   task automatic waitFrames(input int target);
      int n;
      n = 0;
      while (i_rx.frames < target && n < 20000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20000) begin
         check(1'b0, "no frame decoded");
         endOfTest;
      end
   endtask : waitFrames

   function automatic logic [9:0] tcyc(input logic [1:0] m,
                                       input logic [4:0] code);
      int ns10;
      ns10 = (m == 2'h1 || m == 2'h2) ? int'(TICK_STD_NS10[code[3:0]])
         : int'(TICK_ADDR_NS10[code]);
      return 10'((ns10 * 10 + 12) / 25);
   endfunction : tcyc

   // Count nibbles are unknown ahead, so the decoded ones feed the CRC
   task automatic checkFrame(input logic [1:0] cfg);
      int nd;
      int len;
      logic [3:0] c;
      logic [11:0] cnt;
      nd = (cfg == 2'h0) ? 3 : 6;
      cnt = {i_rx.nib[4], i_rx.nib[5], i_rx.nib[6]};
      expNib[0] = {slowSerDis ? 2'h0 : serialBits, devStatus};
      {expNib[1], expNib[2], expNib[3]} = magOut;
      case (cfg)
         2'h1: {expNib[4], expNib[5], expNib[6]} = {diagFlags, cnt[3:0]};
         2'h2: {expNib[4], expNib[5], expNib[6]} = cnt;
         default: {expNib[4], expNib[5], expNib[6]} = tempOut;
      endcase
      c = 4'h5;
      for (int k = crcHasStatus ? 0 : 1; k <= nd + 1; k++) begin
         for (int b = 3; b >= 0; b--) begin
            c = {c[2:0], (k <= nd) ? expNib[k][b] : 1'b0}
               ^ (c[3] ? 4'hD : 4'h0);
         end
      end
      expNib[nd + 1] = c;
      len = 56;
      for (int k = 0; k <= nd + 1; k++) begin
         check(i_rx.nib[k] === expNib[k], "nib");
         len += 12 + int'(expNib[k]);
      end
      check(actCyc - act0 == len * int'(tickCyc), "frame span");
      if (cfg == 2'h2) begin
         check(frameCount === cnt + 12'h001, "frame counter");
      end
      if (cfg == 2'h2 && prevCnt >= 0) begin
         check(int'(cnt) == prevCnt + 1, "frame count step");
      end
      prevCnt = (cfg == 2'h2) ? int'(cnt) : -1;
      check(i_rx.badLow == 0, "pulse shape");
   endtask : checkFrame

   initial begin
      repeat (6) @(posedge clk);
      #2;
      rst_n = 1'b1;
      repeat (2000) @(posedge clk);
      check(i_rx.frames == 0 && lineOe === 1'b0, "idle line");
      check(lineOut === 1'b0 && frameActive === 1'b0, "idle");
      i_rx.pulse(40);
      repeat (3000) @(posedge clk);
      check(i_rx.frames == 0, "short trigger answered");
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         #2;
         msgMode = msg_mode_t'(MODES[i]);
         dataCfg = CFGS[i];
         tickCode = CODES[i];
         crcHasStatus = CFGS[i][0];
         slowSerDis = CFGS[i][1];
         magOut = 12'h3C1 + 12'(i * 273);
         nData = (CFGS[i] == 2'h0) ? 3'h3 : 3'h6;
         tickCyc = tcyc(MODES[i], CODES[i]);
         mark = i_rx.frames;
         act0 = actCyc;
         i_rx.pulse(80);
         repeat (320) @(posedge clk);
         check(sampleFresh === 1'b1, "sample not latched");
         waitFrames(mark + 1);
         check(frameActive === 1'b0, "frame not closed");
         check(sampleFresh === 1'b0, "sample not used");
         span = i_rx.syncStart - i_rx.trigRise;
         check(span >= 7 * tickCyc, "high gap");
         span = i_rx.syncEnd - i_rx.trigFall;
         check(span >= TRIG_SYNC_CYC && span <= TRIG_SYNC_CYC + tickCyc + 8,
            "fall to sync end");
         checkFrame(CFGS[i]);
         repeat (8 * tickCyc) @(posedge clk);
      end
      // Continuous frames with no trigger; last one must carry new data
      @(posedge clk);
      #2;
      msgMode = MODE_INT_SYNC;
      tickCode = 5'h0C;
      dataCfg = 2'h0;
      crcHasStatus = 1'b1;
      slowSerDis = 1'b0;
      nData = 3'h3;
      tickCyc = tcyc(2'h1, 5'h0C);
      mark = i_rx.frames;
      waitFrames(mark + 1);
      #2;
      magOut = 12'h5A7;
      waitFrames(mark + 2);
      act0 = actCyc;
      waitFrames(mark + 3);
      checkFrame(2'h0);
      endOfTest;
   end
endmodule : sent_frame_transmitter_tb

// *** test/sent_receiver_model.sv ***
// Purpose: Receiver side of the SENT line: trigger pulses and frame decoding
// Assumes: Tick period in cycles is set by the bench before each frame
// Notes: A frame is found by a 56 tick fall-to-fall interval only
`timescale 1ns/1ps
module sent_receiver_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line
   input wire logic lineWire,
   output logic pullLow,
   // Decoder setup
   input wire logic [9:0] tickCyc,
   input wire logic [2:0] nData
);
   int cyc = 0;
   int lastFall = 0;
   int idx = -1;
   int frames = 0;
   int badLow = 0;
   int syncStart, syncEnd, trigFall, trigRise, span;
   logic wireQ = 1'b1;
   logic [3:0] nib [8];

   initial pullLow = 1'b0;

   // Line held low, then released; short pulses test the refusal
   task automatic pulse(input int lowCyc);
      @(posedge clk);
      #2;
      pullLow = 1'b1;
      trigFall = cyc;
      repeat (lowCyc) @(posedge clk);
      #2;
      pullLow = 1'b0;
      trigRise = cyc;
   endtask : pulse

   // Intervals must be whole ticks; low phases are checked inside frames
   always @(posedge clk) begin
      wireQ <= lineWire;
      cyc <= cyc + 1;
      span = cyc - lastFall;
      if (!rst_n) begin
         idx <= -1;
      end else if (wireQ && !lineWire) begin
         lastFall <= cyc;
         if (idx < 0 && span == 56 * tickCyc) begin
            idx <= 0;
            syncStart <= lastFall;
            syncEnd <= cyc;
         end else if (idx >= 0) begin
            nib[idx] <= 4'(span / tickCyc - 12);
            if (span % tickCyc != 0) begin
               badLow <= badLow + 1;
            end
            if (idx == int'(nData) + 1) begin
               idx <= -1;
               frames <= frames + 1;
            end else begin
               idx <= idx + 1;
            end
         end
      end else if (!wireQ && lineWire && idx >= 0) begin
         if (span != 5 * tickCyc) begin
            badLow <= badLow + 1;
         end
      end
   end
endmodule : sent_receiver_model
